/* clock_gen.v */
// Clock generation, timewheels and divider bank of the microcontroller clocking system
// Behaviour
// - Fast oscillator offers 3 to 74 MHz
// - Doubler gives twice its input rate
// - Doubler source: oscillator, crystal or interconnect
// - PLL reference selectable, 4032 divider ratios
// - Lock bit set, expected within 250 us
// - Lock indication routed to interconnect
// - Low-speed oscillator yields 1, 33, 100 kHz
// - Central timewheel: 13-bit, advanced by 1 kHz
// - Central timewheel stops in hibernate or debug halt
// - Software can reset central timewheel
// - Periodic wake events, optional interrupt
// - Fast timewheel: 5-bit, programmable terminal count
// - Optional interrupt at fast terminal count
// - 33 kHz is 100 kHz divided by three
// - 1 kHz clock has half duty, 33 kHz clock is high two thirds
// - Once-per-second interrupt from watch crystal
// - Eight extra interconnect clocks feed dividers
// - Bus clock via 16-bit divider, CPU equal
// - Eight digital, four skewed analog dividers
// - Divider: 8-input mux, 16-bit, resynchronised
// - Divider output chains into next divider
`timescale 1ns/1ps
`default_nettype none
`include "clock_gen_defines.vh"
module clock_gen #(
   parameter LOCK_CYCLES = `PLL_LOCK_US * `CLK_MHZ,
   parameter NUM_DIGITAL = 8,
   parameter NUM_ANALOG = 4
) (
   input wire clk,
   input wire reset,
   input wire [`ADDR_WIDTH-1:0] address,
   input wire [31:0] writeData,
   input wire writeStrobe,
   input wire readStrobe,
   output reg [31:0] readData,
   input wire fastInternalOsc,
   input wire mhzCrystalOsc,
   input wire interconnectClock,
   input wire [7:0] interconnectClocks,
   input wire pllClock,
   input wire pllLockRaw,
   input wire lowSpeedInternalOsc,
   input wire watchCrystalOsc,
   input wire hibernate,
   input wire debugHalt,
   output reg [2:0] fastOscFreq,
   output reg doublerEnable,
   output reg [1:0] doublerSource,
   output reg serialBusTick,
   output reg pllEnable,
   output reg [1:0] pllSource,
   output reg [5:0] pllInputDiv,
   output reg [5:0] pllFeedbackDiv,
   output reg pllLockRoute,
   output reg lowSpeedFastClock,
   output wire lowSpeedMidClock,
   output wire slowTickClock,
   output reg ctwWake,
   output reg ctwIrq,
   output reg ftwIrq,
   output reg rtcIrq,
   output wire busClock,
   output wire cpuClock,
   output reg [NUM_DIGITAL+NUM_ANALOG-1:0] dividedClocks
);
   localparam NUM_DIV = NUM_DIGITAL + NUM_ANALOG;
   localparam NUM_SYNC = 17;
   localparam I_FAST = 0;
   localparam I_XTAL = 1;
   localparam I_ICON = 2;
   localparam I_PLL = 3;
   localparam I_LSO = 4;
   localparam I_WATCH = 5;
   localparam I_LOCK = 6;
   localparam I_HIB = 7;
   localparam I_DBG = 8;
   localparam I_EXTRA = 9;
   // Reset image of the divider register; both fields are cut from it
   localparam [15:0] PLLCFG_INIT = `PLLCFG_RESET;

   // Pin inputs: two flops, then an edge stage
   wire [NUM_SYNC-1:0] rawIn = {interconnectClocks, debugHalt, hibernate, pllLockRaw, watchCrystalOsc,
                                lowSpeedInternalOsc, pllClock, interconnectClock, mhzCrystalOsc, fastInternalOsc};
   reg [NUM_SYNC-1:0] syncA;
   reg [NUM_SYNC-1:0] syncB;
   reg [NUM_SYNC-1:0] syncC;
   wire [NUM_SYNC-1:0] rise = syncB & ~syncC;
   wire [NUM_SYNC-1:0] fall = ~syncB & syncC;

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         syncA <= {NUM_SYNC{1'b0}};
         syncB <= {NUM_SYNC{1'b0}};
         syncC <= {NUM_SYNC{1'b0}};
      end else begin
         syncA <= rawIn;
         syncB <= syncA;
         syncC <= syncB;
      end
   end

   // Software state
   reg ctwWakeEn;
   reg ctwIrqEn;
   reg ftwIrqEn;
   reg rtcIrqEn;
   reg ftwEnable;
   reg ctwSwReset;
   reg [3:0] wakeTap;
   reg [4:0] ftwTerminal;
   reg [15:0] busDivide;
   reg [21:0] divCfg [0:NUM_DIV-1];
   reg pllLate;
   reg ctwFlag;
   reg ftwFlag;
   reg rtcFlag;
   reg [12:0] ctwCount;
   reg [4:0] ftwCount;
   reg [31:0] lockTimer;
   reg pllLock;

   wire writeCtrl = writeStrobe && (address == `REG_CTRL);
   wire clearStatus = writeStrobe && (address == `REG_STATUS);
   wire [`ADDR_WIDTH-1:0] divOffset = address - `REG_DIVBASE;
   wire divHit = (address >= `REG_DIVBASE) && (divOffset[1:0] == 2'b00) && ((divOffset >> 2) < NUM_DIV);
   wire [3:0] divIndex = divOffset[5:2];
   wire [15:0] ctrlImage = {ftwEnable, rtcIrqEn, doublerEnable, ftwIrqEn, ctwIrqEn, ctwWakeEn, 1'b0, pllEnable,
                            pllSource, doublerSource, 1'b0, fastOscFreq};

   integer i;
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         fastOscFreq <= `FREQ_3MHZ;
         doublerSource <= `SRC_FAST_OSC;
         pllSource <= `SRC_FAST_OSC;
         pllEnable <= 1'b0;
         ctwSwReset <= 1'b0;
         ctwWakeEn <= 1'b0;
         ctwIrqEn <= 1'b0;
         ftwIrqEn <= 1'b0;
         doublerEnable <= 1'b0;
         rtcIrqEn <= 1'b0;
         ftwEnable <= 1'b0;
         pllInputDiv <= PLLCFG_INIT[5:0];
         pllFeedbackDiv <= PLLCFG_INIT[13:8];
         wakeTap <= `CTWCFG_RESET;
         ftwTerminal <= `FTWCFG_RESET;
         busDivide <= `BUSDIV_RESET;
         for (i = 0; i < NUM_DIV; i = i + 1) begin
            divCfg[i] <= `DIVCFG_RESET;
         end
      end else begin
         ctwSwReset <= 1'b0;
         if (writeCtrl) begin
            fastOscFreq <= (writeData[2:0] > `FREQ_74MHZ) ? `FREQ_74MHZ : writeData[2:0];
            doublerSource <= (writeData[5:4] > `SRC_INTERCONNECT) ? `SRC_INTERCONNECT : writeData[5:4];
            pllSource <= (writeData[7:6] > `SRC_INTERCONNECT) ? `SRC_INTERCONNECT : writeData[7:6];
            pllEnable <= writeData[`CTRL_PLLEN];
            ctwSwReset <= writeData[`CTRL_CTWRST];
            ctwWakeEn <= writeData[`CTRL_CTWWAKE];
            ctwIrqEn <= writeData[`CTRL_CTWIRQ];
            ftwIrqEn <= writeData[`CTRL_FTWIRQ];
            doublerEnable <= writeData[`CTRL_DBLEN];
            rtcIrqEn <= writeData[`CTRL_RTCIRQ];
            ftwEnable <= writeData[`CTRL_FTWEN];
         end
         if (writeStrobe && address == `REG_PLLCFG) begin
            pllInputDiv <= writeData[5:0];
            pllFeedbackDiv <= (writeData[13:8] == 6'h00) ? 6'h01 : writeData[13:8];
         end
         if (writeStrobe && address == `REG_CTWCFG) begin
            wakeTap <= (writeData[3:0] > 4'hC) ? 4'hC : writeData[3:0];
         end
         if (writeStrobe && address == `REG_FTWCFG) begin
            ftwTerminal <= writeData[4:0];
         end
         if (writeStrobe && address == `REG_BUSDIV) begin
            busDivide <= writeData[15:0];
         end
         if (writeStrobe && divHit) begin
            divCfg[divIndex] <= writeData[21:0];
         end
      end
   end

   // Read port: data only in the cycle after the strobe
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         readData <= 32'h0000_0000;
      end else if (readStrobe) begin
         case (address)
            `REG_CTRL: readData <= {16'h0000, ctrlImage};
            `REG_PLLCFG: readData <= {18'h0_0000, pllFeedbackDiv, 2'b00, pllInputDiv};
            `REG_STATUS: readData <= {27'h000_0000, rtcFlag, ftwFlag, ctwFlag, pllLate, pllLock};
            `REG_CTWCFG: readData <= {28'h000_0000, wakeTap};
            `REG_FTWCFG: readData <= {27'h000_0000, ftwTerminal};
            `REG_BUSDIV: readData <= {16'h0000, busDivide};
            `REG_COUNT: readData <= {11'h000, ftwCount, 3'h0, ctwCount};
            default: readData <= divHit ? {10'h000, divCfg[divIndex]} : 32'h0000_0000;
         endcase
      end else begin
         readData <= 32'h0000_0000;
      end
   end

   reg [NUM_SYNC-1:0] dblEdge;
   always @* begin
      dblEdge = rise | fall;
   end
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         serialBusTick <= 1'b0;
      end else begin
         case (doublerSource)
            `SRC_FAST_OSC: serialBusTick <= doublerEnable & dblEdge[I_FAST];
            `SRC_CRYSTAL: serialBusTick <= doublerEnable & dblEdge[I_XTAL];
            default: serialBusTick <= doublerEnable & dblEdge[I_ICON];
         endcase
      end
   end

   // Lock from the analog loop; late flag if it overruns the window
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         lockTimer <= 32'h0000_0000;
         pllLock <= 1'b0;
         pllLate <= 1'b0;
         pllLockRoute <= 1'b0;
      end else begin
         pllLock <= pllEnable & syncB[I_LOCK];
         pllLockRoute <= pllEnable & syncB[I_LOCK];
         if (!pllEnable || pllLock) begin
            lockTimer <= 32'h0000_0000;
         end else if (lockTimer < LOCK_CYCLES) begin
            lockTimer <= lockTimer + 1'b1;
         end
         if (pllEnable && !pllLock && lockTimer == LOCK_CYCLES - 1) begin
            pllLate <= 1'b1;
         end else if (clearStatus && writeData[`STAT_LATE]) begin
            pllLate <= 1'b0;
         end
      end
   end

   // Low-speed clocks
   wire lsoTick = rise[I_LSO];
   wire midTick;
   wire slowTick;
   wire secondTick;
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         lowSpeedFastClock <= 1'b0;
      end else begin
         lowSpeedFastClock <= syncB[I_LSO];
      end
   end

   clock_divider #(.WIDTH(16)) midDivider (
      .clk(clk), .reset(reset), .sources({7'h00, lsoTick}), .select(3'h0),
      .divide(`MID_DIVIDE), .divClock(lowSpeedMidClock), .riseTick(midTick)
   );
   clock_divider #(.WIDTH(16)) slowDivider (
      .clk(clk), .reset(reset), .sources({7'h00, lsoTick}), .select(3'h0),
      .divide(`SLOW_DIVIDE), .divClock(slowTickClock), .riseTick(slowTick)
   );
   clock_divider #(.WIDTH(16)) secondDivider (
      .clk(clk), .reset(reset), .sources({7'h00, rise[I_WATCH]}), .select(3'h0),
      .divide(`WATCH_DIVIDE), .divClock(), .riseTick(secondTick)
   );
   clock_divider #(.WIDTH(16)) busDivider (
      .clk(clk), .reset(reset), .sources(8'h01), .select(3'h0),
      .divide(busDivide), .divClock(busClock), .riseTick()
   );
   // CPU clock is the bus clock
   assign cpuClock = busClock;

   // Timewheels; event set beats a same-cycle clear
   wire [12:0] ctwNext = ctwCount + 1'b1;
   wire [12:0] tapMask = (13'h0002 << wakeTap) - 13'h0001;
   wire ctwRun = slowTick && !syncB[I_HIB] && !syncB[I_DBG];
   wire ctwEvent = ctwRun && ((ctwNext & tapMask) == 13'h0000);
   wire ftwRun = lsoTick && ftwEnable;
   wire ftwEvent = ftwRun && (ftwCount == ftwTerminal);

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         ctwCount <= 13'h0000;
         ftwCount <= 5'h00;
         ctwWake <= 1'b0;
         ctwFlag <= 1'b0;
         ftwFlag <= 1'b0;
         rtcFlag <= 1'b0;
         ctwIrq <= 1'b0;
         ftwIrq <= 1'b0;
         rtcIrq <= 1'b0;
      end else begin
         if (ctwSwReset) begin
            ctwCount <= 13'h0000;
         end else if (ctwRun) begin
            ctwCount <= ctwNext;
         end
         ctwWake <= ctwEvent && ctwWakeEn && !ctwSwReset;
         if (ctwEvent && ctwIrqEn && !ctwSwReset) begin
            ctwFlag <= 1'b1;
         end else if (clearStatus && writeData[`STAT_CTW]) begin
            ctwFlag <= 1'b0;
         end
         if (!ftwEnable) begin
            ftwCount <= 5'h00;
         end else if (ftwEvent) begin
            ftwCount <= 5'h00;
         end else if (ftwRun) begin
            ftwCount <= ftwCount + 1'b1;
         end
         if (ftwEvent && ftwIrqEn) begin
            ftwFlag <= 1'b1;
         end else if (clearStatus && writeData[`STAT_FTW]) begin
            ftwFlag <= 1'b0;
         end
         if (secondTick && rtcIrqEn) begin
            rtcFlag <= 1'b1;
         end else if (clearStatus && writeData[`STAT_RTC]) begin
            rtcFlag <= 1'b0;
         end
         ctwIrq <= ctwFlag;
         ftwIrq <= ftwFlag;
         rtcIrq <= rtcFlag;
      end
   end

   // Divider bank; analog ones get a skew delay so edges avoid digital switching
   wire [NUM_DIV-1:0] divRaw;
   wire [NUM_DIV-1:0] divTick;
   genvar n;
   generate
      for (n = 0; n < NUM_DIV; n = n + 1) begin : bank
         wire [7:0] srcs;
         // Own interconnect clock for digital ones
         assign srcs = {(n == 0) ? 1'b0 : divTick[(n + NUM_DIV - 1) % NUM_DIV],
                        (n < NUM_DIGITAL) ? rise[I_EXTRA + (n % 8)] : rise[I_ICON],
                        rise[I_WATCH], lsoTick, rise[I_PLL], rise[I_ICON], rise[I_XTAL], rise[I_FAST]};
         clock_divider #(.WIDTH(16)) divider (
            .clk(clk), .reset(reset), .sources(srcs), .select(divCfg[n][18:16]),
            .divide(divCfg[n][15:0]), .divClock(divRaw[n]), .riseTick(divTick[n])
         );
         reg [3:0] skewLine;
         always @(posedge clk or posedge reset) begin
            if (reset) begin
               skewLine <= 4'h0;
               dividedClocks[n] <= 1'b0;
            end else begin
               skewLine <= {skewLine[2:0], divRaw[n]};
               if (n >= NUM_DIGITAL) begin
                  dividedClocks[n] <= skewLine[divCfg[n][21:20]];
               end else begin
                  dividedClocks[n] <= divRaw[n];
               end
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

/* clock_gen_defines.vh */
// Register map, field positions, reset values and timing figures of the clock generator
`ifndef CLOCK_GEN_DEFINES_VH
`define CLOCK_GEN_DEFINES_VH

`define ADDR_WIDTH 8
`define REG_CTRL 8'h00
`define REG_PLLCFG 8'h04
`define REG_STATUS 8'h08
`define REG_CTWCFG 8'h0C
`define REG_FTWCFG 8'h10
`define REG_BUSDIV 8'h14
`define REG_COUNT 8'h18
`define REG_DIVBASE 8'h40

`define CTRL_RESET 16'h0000
`define CTRL_FREQ_LSB 0
`define CTRL_DBLSRC_LSB 4
`define CTRL_PLLSRC_LSB 6
`define CTRL_PLLEN 8
`define CTRL_CTWRST 9
`define CTRL_CTWWAKE 10
`define CTRL_CTWIRQ 11
`define CTRL_FTWIRQ 12
`define CTRL_DBLEN 13
`define CTRL_RTCIRQ 14
`define CTRL_FTWEN 15

`define STAT_LOCK 0
`define STAT_LATE 1
`define STAT_CTW 2
`define STAT_FTW 3
`define STAT_RTC 4

`define FREQ_3MHZ 3'h0
`define FREQ_6MHZ 3'h1
`define FREQ_12MHZ 3'h2
`define FREQ_24MHZ 3'h3
`define FREQ_48MHZ 3'h4
`define FREQ_74MHZ 3'h5

`define SRC_FAST_OSC 2'h0
`define SRC_CRYSTAL 2'h1
`define SRC_INTERCONNECT 2'h2

`define PLLCFG_RESET 16'h0100
`define CTWCFG_RESET 4'h9
`define FTWCFG_RESET 5'h1F
`define BUSDIV_RESET 16'h0002
`define DIVCFG_RESET 22'h00_0002

`define CLK_MHZ 200
`define PLL_LOCK_US 250
`define MID_DIVIDE 16'h0003
`define SLOW_DIVIDE 16'h0064
`define WATCH_DIVIDE 16'h8000

`endif

/* clock_divider.v */
// One 16-bit clock divider with source multiplexer and boundary-only reconfiguration
`timescale 1ns/1ps
`default_nettype none
module clock_divider #(
   parameter WIDTH = 16
) (
   input wire clk,
   input wire reset,
   input wire [7:0] sources,
   input wire [2:0] select,
   input wire [WIDTH-1:0] divide,
   output reg divClock,
   output reg riseTick
);
   localparam [WIDTH-1:0] MIN_DIV = 2;
   reg [2:0] activeSel;
   reg [WIDTH-1:0] activeDiv;
   reg [WIDTH-1:0] count;
   wire tick = sources[activeSel];
   wire [WIDTH-1:0] limit = (activeDiv < MIN_DIV) ? MIN_DIV : activeDiv;
   wire [WIDTH-1:0] half = limit - (limit >> 1);
   wire [WIDTH-1:0] countNext = count + 1'b1;
   wire wrap = (countNext == limit);

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         activeSel <= 3'h0;
         activeDiv <= MIN_DIV;
         count <= {WIDTH{1'b0}};
         divClock <= 1'b0;
         riseTick <= 1'b0;
      end else begin
         riseTick <= 1'b0;
         if (tick) begin
            if (wrap) begin
               count <= {WIDTH{1'b0}};
               activeSel <= select;
               activeDiv <= divide;
               divClock <= 1'b1;
               riseTick <= 1'b1;
            end else begin
               count <= countNext;
               divClock <= (countNext < half);
            end
         end
      end
   end
endmodule
`default_nettype wire

/* clock_gen_assertions.sv */
// Port-level assertions for the clock generator
`timescale 1ns/1ps
`default_nettype none
module clock_gen_checker (
   input wire clk,
   input wire reset,
   input wire hibernate,
   input wire [2:0] fastOscFreq,
   input wire doublerEnable,
   input wire serialBusTick,
   input wire pllEnable,
   input wire [1:0] pllSource,
   input wire [5:0] pllFeedbackDiv,
   input wire pllLockRoute,
   input wire ctwWake,
   input wire busClock,
   input wire cpuClock
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_freq_legal: assert property (fastOscFreq <= 3'h5)
      else $error("fast oscillator code out of range");
   a_tick_gate: assert property (!doublerEnable && !$past(doublerEnable) |-> !serialBusTick)
      else $error("doubler tick while disabled");
   a_tick_single: assert property (serialBusTick |=> !serialBusTick)
      else $error("doubler tick longer than one cycle");
   a_pll_source: assert property (pllSource != 2'h3)
      else $error("pll source code out of range");
   a_feedback_nonzero: assert property (pllFeedbackDiv != 6'h00)
      else $error("pll feedback divider zero");
   a_lock_route: assert property (pllLockRoute |-> pllEnable || $past(pllEnable))
      else $error("lock routed while pll disabled");
   a_wake_pulse: assert property (ctwWake |=> !ctwWake)
      else $error("wake event longer than one cycle");
   a_halt_nowake: assert property (hibernate [*6] |-> !ctwWake)
      else $error("wake event during hibernate");
   a_cpu_bus: assert property (cpuClock == busClock)
      else $error("cpu clock differs from bus clock");
endmodule
`default_nettype wire

/* oscillator_model.sv */
// Oscillator pins and analog PLL stand-in
`timescale 1ns/1ps
`default_nettype none
module oscillator_model (
   input wire logic clk,
   input wire logic pllEnable,
   input wire logic slowLock,
   output logic fastInternalOsc,
   output logic mhzCrystalOsc,
   output logic interconnectClock,
   output logic [7:0] interconnectClocks,
   output logic pllClock,
   output logic pllLockRaw,
   output logic lowSpeedInternalOsc,
   output logic watchCrystalOsc
);
   int lockCnt;
   initial begin
      {fastInternalOsc, mhzCrystalOsc, interconnectClock, pllClock} = 4'h0;
      {pllLockRaw, lowSpeedInternalOsc, watchCrystalOsc} = 3'h0;
      interconnectClocks = 8'h55;
      lockCnt = 0;
   end
   // Periods unrelated to clk except lowSpeedInternalOsc at eight clk periods, all slow enough for the pin synchronisers
   always #17 fastInternalOsc = ~fastInternalOsc;
   always #19 mhzCrystalOsc = ~mhzCrystalOsc;
   always #21 interconnectClock = ~interconnectClock;
   always #22 interconnectClocks = ~interconnectClocks;
   always #16 pllClock = ~pllClock;
   always #20 lowSpeedInternalOsc = ~lowSpeedInternalOsc;
   always #23 watchCrystalOsc = ~watchCrystalOsc;
   always @(posedge clk) begin
      if (!pllEnable) begin
         lockCnt <= 0;
         pllLockRaw <= 1'b0;
      end else if (lockCnt < (slowLock ? 60 : 8))
         lockCnt <= lockCnt + 1;
      else
         pllLockRaw <= 1'b1;
   end
endmodule
`default_nettype wire

/* test_clock_gen.sv */
// Self-checking bench for the clock generator
`timescale 1ns/1ps
`default_nettype none
`include "clock_gen_defines.vh"
module test_clock_gen;
   logic clk, reset, writeStrobe, readStrobe, hibernate, debugHalt, slowLock;
   logic [7:0] address;
   logic [31:0] writeData, v, w;
   int err_count, checks_done, cyc, n, p, h, k, s;
   int half [3] = '{17, 19, 21};
   wire fastInternalOsc, mhzCrystalOsc, interconnectClock, pllClock, pllLockRaw;
   wire lowSpeedInternalOsc, watchCrystalOsc;
   wire [7:0] interconnectClocks;
   wire [31:0] readData;
   wire [2:0] fastOscFreq;
   wire [1:0] doublerSource, pllSource;
   wire [5:0] pllInputDiv, pllFeedbackDiv;
   wire doublerEnable, serialBusTick, pllEnable, pllLockRoute, lowSpeedFastClock, lowSpeedMidClock;
   wire slowTickClock, ctwWake, ctwIrq, ftwIrq, rtcIrq, busClock, cpuClock;
   wire [11:0] dividedClocks;
   wire [18:0] taps = {lowSpeedFastClock, slowTickClock, lowSpeedMidClock, ctwWake, ftwIrq, pllLockRoute, busClock,
      dividedClocks};
   logic [39:0] rows [0:8] = '{40'h00_0000_0000, 40'h04_0000_0100, 40'h08_0000_0000, 40'h0C_0000_0009,
      40'h10_0000_001F, 40'h14_0000_0002, 40'h40_0000_0002, 40'h6C_0000_0002, 40'h3C_0000_0000};
   clock_gen #(.LOCK_CYCLES(20)) uut (.*);
   oscillator_model osc (.*);
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Unknown values must fail the range test, not slip through as zero
   task rng(input string what, input logic [31:0] x, input int lo, input int hi);
      check(what, x, (!$isunknown(x) && x >= lo && x <= hi) ? x : lo);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      address <= a;
      writeData <= d;
      writeStrobe <= 1'b1;
      @(posedge clk);
      writeStrobe <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      address <= a;
      readStrobe <= 1'b1;
      @(posedge clk);
      readStrobe <= 1'b0;
      // Data stands for this one cycle; take it at its closing edge
      @(posedge clk);
      d = readData;
   endtask
   task wt(input int i, input logic b, output int c);
      for (c = 0; c < 3000 && taps[i] !== b; c++) @(posedge clk);
   endtask
   task per(input int i);
      wt(i, 1'b0, k);
      wt(i, 1'b1, k);
      p = 0;
      h = 0;
      do begin
         @(posedge clk);
         p++;
         if (h == 0 && taps[i] === 1'b0) h = p;
      end while (p < 3000 && (h == 0 || taps[i] !== 1'b1));
   endtask
   task done(input string t);
      $display("test %s finished", t);
   endtask
   task final_report;
      $display("comparisons %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Ceiling well above the expected run of about ten thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         final_report;
      end
   end
   initial begin
      {reset, writeStrobe, readStrobe, hibernate, debugHalt, slowLock} = 6'b100000;
      address = 8'h00;
      writeData = 32'h0000_0000;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      for (k = 0; k < 9; k++) begin
         rd(rows[k][39:32], v);
         check("reset value", v, rows[k][31:0]);
      end
      wr(8'h3C, 32'hFFFF_FFFF);
      rd(8'h3C, v);
      check("unmapped", v, 32'h0000_0000);
      done("reset");
      for (s = 0; s < 8; s++) begin
         wr(`REG_CTRL, s);
         repeat (2) @(posedge clk);
         check("freq", fastOscFreq, s > 5 ? 5 : s);
      end
      for (s = 0; s < 3; s++) begin
         wr(`REG_CTRL, s << 4);
         wr(`REG_CTRL, 32'h2000 | (s << 4));
         n = 0;
         repeat (400) begin
            @(posedge clk);
            if (serialBusTick === 1'b1) n++;
         end
         check("doubler source", doublerSource, s);
         rng("doubler ticks", n, 2000 / half[s] - 4, 2000 / half[s] + 4);
      end
      done("doubler");
      wr(`REG_CTRL, 32'h01C0);
      wr(`REG_PLLCFG, 32'h0A05);
      repeat (2) @(posedge clk);
      check("pll source", pllSource, 2);
      check("pll dividers", {pllFeedbackDiv, pllInputDiv}, 12'h285);
      wr(`REG_PLLCFG, 32'h0003);
      repeat (2) @(posedge clk);
      check("feedback zero", pllFeedbackDiv, 1);
      wt(13, 1'b1, n);
      rng("lock wait", n, 1, 30);
      rd(`REG_STATUS, v);
      check("lock bit", v[1:0], 2'b01);
      wr(`REG_CTRL, 32'h0000);
      slowLock <= 1'b1;
      repeat (5) @(posedge clk);
      wr(`REG_CTRL, 32'h0100);
      wt(13, 1'b1, n);
      rd(`REG_STATUS, v);
      check("late lock", v[1:0], 2'b11);
      wr(`REG_STATUS, 32'h0002);
      rd(`REG_STATUS, v);
      check("late cleared", v[1], 1'b0);
      wr(`REG_CTRL, 32'h0000);
      done("pll");
      wr(`REG_BUSDIV, 32'h0004);
      repeat (20) @(posedge clk);
      per(12);
      check("bus period", p, 4);
      check("bus high", h, 2);
      wr(`REG_BUSDIV, 32'h0001);
      repeat (20) @(posedge clk);
      per(12);
      check("bus minimum", p, 2);
      wr(8'h40, 32'h0004);
      wr(8'h44, 32'h0007_0002);
      wr(8'h60, 32'h0030_0004);
      repeat (100) @(posedge clk);
      per(0);
      rng("div period", p, 26, 29);
      rng("div high", h, 12, 15);
      per(1);
      rng("chain period", p, 53, 56);
      per(8);
      rng("analog period", p, 26, 29);
      // Change lands mid-period on purpose
      wr(8'h40, 32'h0008);
      per(0);
      rng("switch high", h, 12, 29);
      rng("switch period", p, 26, 56);
      per(0);
      rng("new period", p, 53, 56);
      per(16);
      rng("mid clock", p, 23, 25);
      per(17);
      rng("tick clock", p, 798, 802);
      rng("tick high", h, 398, 402);
      per(18);
      rng("fast low clock", p, 7, 9);
      done("dividers");
      wr(`REG_CTWCFG, 32'h0000);
      wr(`REG_CTRL, 32'h0C00);
      wt(15, 1'b1, n);
      wt(15, 1'b0, n);
      wt(15, 1'b1, n);
      rng("wake period", n, 1596, 1602);
      wr(`REG_CTRL, 32'h0E00);
      rd(`REG_COUNT, v);
      check("ctw reset", v[12:0], 13'h0000);
      check("ctw irq", ctwIrq, 1'b1);
      wr(`REG_STATUS, 32'h0004);
      repeat (3) @(posedge clk);
      check("ctw irq clear", ctwIrq, 1'b0);
      for (s = 0; s < 2; s++) begin
         {hibernate, debugHalt} <= s ? 2'b01 : 2'b10;
         repeat (6) @(posedge clk);
         rd(`REG_COUNT, v);
         // A full tick passes while halted; release just after a fall so one tick follows
         wt(17, 1'b0, n);
         wt(17, 1'b1, n);
         wt(17, 1'b0, n);
         {hibernate, debugHalt} <= 2'b00;
         rd(`REG_COUNT, w);
         check("ctw halted", w[12:0], v[12:0]);
         wt(17, 1'b1, n);
         repeat (2) @(posedge clk);
         rd(`REG_COUNT, v);
         check("ctw runs", v[12:0], w[12:0] + 13'h0001);
      end
      done("central timewheel");
      wr(`REG_FTWCFG, 32'h0003);
      wr(`REG_CTRL, 32'hD000);
      wt(14, 1'b1, n);
      rng("ftw irq wait", n, 1, 100);
      for (s = 0; s < 6; s++) begin
         rd(`REG_COUNT, v);
         rng("ftw count", v[20:16], 0, 3);
      end
      wr(`REG_CTRL, 32'h8000);
      wr(`REG_STATUS, 32'h0008);
      repeat (3) @(posedge clk);
      check("ftw irq clear", ftwIrq, 1'b0);
      check("rtc idle", rtcIrq, 1'b0);
      done("fast timewheel");
      reset <= 1'b1;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      rd(`REG_BUSDIV, v);
      check("second reset", v, 32'h0000_0002);
      done("second reset");
      final_report;
   end
endmodule
bind clock_gen clock_gen_checker chk (.clk, .reset, .hibernate, .fastOscFreq, .doublerEnable, .serialBusTick,
   .pllEnable, .pllSource, .pllFeedbackDiv, .pllLockRoute, .ctwWake, .busClock, .cpuClock);
`default_nettype wire
